// ### hdl/sld_pkg.sv
// Types shared by the strap latch decoder and its input synchroniser.
// Assumes sld_regs.svh is compiled alongside.
`include "sld_regs.svh"

package sld_pkg;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [2:0] {
      SLD_HOLD,
      SLD_SETTLE,
      SLD_LATCH,
      SLD_RUN
   } sld_fsm_t;

   typedef enum logic [2:0] {
      bridge_master_setting,
      hub_config_slave_setting,
      reserved_setting_a,
      reserved_setting_b,
      reserved_setting_c,
      reserved_setting_d
   } sld_mode_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [`SLD_CODE_W-1:0] mode_code;
      logic [`SLD_PORTS-1:0]  dplus_off;
      logic [`SLD_PORTS-1:0]  dminus_off;
   } sld_strap_t;

   typedef struct packed {
      logic                  valid;
      logic                  in_reset;
      sld_mode_t             mode;
      logic                  smbus_master;
      logic                  smbus_slave;
      logic                  mode_reserved;
      logic [`SLD_PORTS-1:0] usb2_off;
      logic [`SLD_PORTS-1:0] usb3_off;
   } sld_cfg_t;

   typedef struct packed {
      sld_fsm_t              fsm;
      logic [`SLD_CNT_W-1:0] cnt;
      sld_strap_t            strap;
      sld_cfg_t              cfg;
   } sld_state_t;

   typedef struct packed {
      logic [`SLD_SYNC_W-1:0] ff1;
      logic [`SLD_SYNC_W-1:0] ff2;
      logic [`SLD_SYNC_W-1:0] ff3;
      logic [`SLD_SYNC_W-1:0] filt;
   } sld_sync_t;

endpackage

// ### hdl/sld_regs.svh
// Strap latch decoder constants: timing, widths, codes, reset values.
// Assumes inclusion by bare name from the hdl/ folder.
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH

// ****************************************
// Widths
// ****************************************
`define SLD_PORTS        6
`define SLD_CODE_W       3
`define SLD_CNT_W        4
// Reset pin, mode code, D+ straps, D- straps
`define SLD_SYNC_W       16

// ****************************************
// Sync bus field positions
// ****************************************
`define SLD_POS_RST      0
`define SLD_POS_CODE     1
`define SLD_POS_DP       4
`define SLD_POS_DM       10

// ****************************************
// Timing
// ****************************************
`define SLD_CLK_NS       4
`define SLD_SETTLE_NS    16
`define SLD_SETTLE_CYC   ((`SLD_SETTLE_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)

// ****************************************
// Mode strap codes from the level sensor
// ****************************************
`define SLD_CODE_BRIDGE  3'h0
`define SLD_CODE_SLAVE   3'h1
`define SLD_CODE_RES_A   3'h2
`define SLD_CODE_RES_B   3'h3
`define SLD_CODE_RES_C   3'h4
`define SLD_CODE_RES_D   3'h5

// ****************************************
// Reset values
// ****************************************
`define SLD_PORT_OFF_RST 6'h3F
`define SLD_SYNC_RST     16'h0000

`endif

// ### hdl/sld_strap_latch.sv
// Strap latch decoder: captures strap pins at reset release, decodes defaults.
// Assumes the mode strap level is already resolved to a 3-bit code by a sensor.
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_strap_latch (
   // Clock and power-on reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rstn,
   // Pins
   input  wire logic                  i_ext_reset_n,
   input  wire logic [`SLD_CODE_W-1:0] i_mode_strap_code,
   input  wire logic [`SLD_PORTS-1:0] i_port_dplus_off_strap,
   input  wire logic [`SLD_PORTS-1:0] i_port_dminus_off_strap,
   // Status
   output logic                       o_hub_in_reset,
   output logic                       o_cfg_valid,
   // Decoded configuration
   output sld_pkg::sld_mode_t         o_mode,
   output logic                       o_smbus_master,
   output logic                       o_smbus_slave,
   output logic                       o_mode_reserved,
   output logic [`SLD_PORTS-1:0]      o_usb2_port_off,
   output logic [`SLD_PORTS-1:0]      o_usb3_port_off
);

   localparam logic [`SLD_CNT_W-1:0] SETTLE_CNT = `SLD_CNT_W'(`SLD_SETTLE_CYC - 1);

   sld_pkg::sld_state_t     st_reg;
   sld_pkg::sld_state_t     st_next;
   logic [`SLD_SYNC_W-1:0]  pins;
   logic [`SLD_SYNC_W-1:0]  sync;
   logic                    ext_rstn_sync;
   sld_pkg::sld_strap_t     strap_sync;
   sld_pkg::sld_mode_t      mode_dec;
   logic [`SLD_PORTS-1:0]   port_off_dec;

   // ****************************************
   // Pin synchronisation
   // ****************************************
   assign pins = {i_port_dminus_off_strap, i_port_dplus_off_strap,
                  i_mode_strap_code, i_ext_reset_n};

   sld_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_pins     (pins),
      .o_sync     (sync)
   );

   assign ext_rstn_sync         = sync[`SLD_POS_RST];
   assign strap_sync.mode_code  = sync[`SLD_POS_CODE +: `SLD_CODE_W];
   assign strap_sync.dplus_off  = sync[`SLD_POS_DP +: `SLD_PORTS];
   assign strap_sync.dminus_off = sync[`SLD_POS_DM +: `SLD_PORTS];

   // ****************************************
   // Decode of held straps
   // ****************************************
   always_comb begin
      case (st_reg.strap.mode_code)
         `SLD_CODE_BRIDGE: mode_dec = sld_pkg::bridge_master_setting;
         `SLD_CODE_SLAVE:  mode_dec = sld_pkg::hub_config_slave_setting;
         `SLD_CODE_RES_A:  mode_dec = sld_pkg::reserved_setting_a;
         `SLD_CODE_RES_B:  mode_dec = sld_pkg::reserved_setting_b;
         `SLD_CODE_RES_C:  mode_dec = sld_pkg::reserved_setting_c;
         // Codes the sensor never produces fall into the inert reserved group
         default:          mode_dec = sld_pkg::reserved_setting_d;
      endcase
   end

   // A single high strap leaves the port on; both must be high
   assign port_off_dec = st_reg.strap.dplus_off & st_reg.strap.dminus_off;

   // ****************************************
   // Latch sequencer
   // ****************************************
   always_comb begin
      st_next = st_reg;
      case (st_reg.fsm)
         sld_pkg::SLD_HOLD: begin
            st_next.cfg.in_reset = 1'b1;
            if (ext_rstn_sync) begin
               // Synchroniser delay plus settle margin before capture
               st_next.fsm = sld_pkg::SLD_SETTLE;
               st_next.cnt = SETTLE_CNT;
            end
         end
         sld_pkg::SLD_SETTLE: begin
            if (st_reg.cnt == '0) begin
               st_next.fsm = sld_pkg::SLD_LATCH;
            end else begin
               st_next.cnt = st_reg.cnt - `SLD_CNT_W'(1);
            end
         end
         sld_pkg::SLD_LATCH: begin
            st_next.strap = strap_sync;
            st_next.fsm   = sld_pkg::SLD_RUN;
         end
         sld_pkg::SLD_RUN: begin
            // Straps are no longer looked at; only a new reset reopens the latch
            st_next.cfg.valid         = 1'b1;
            st_next.cfg.in_reset      = 1'b0;
            st_next.cfg.mode          = mode_dec;
            st_next.cfg.smbus_master  = (mode_dec == sld_pkg::bridge_master_setting);
            st_next.cfg.smbus_slave   = (mode_dec == sld_pkg::hub_config_slave_setting);
            st_next.cfg.mode_reserved = !st_next.cfg.smbus_master &&
                                        !st_next.cfg.smbus_slave;
            st_next.cfg.usb2_off      = port_off_dec;
            st_next.cfg.usb3_off      = port_off_dec;
         end
         default: begin
            st_next.fsm = sld_pkg::SLD_HOLD;
         end
      endcase
      // External reset wins in every state; standby clears the configuration except the decoded mode
      if (!ext_rstn_sync) begin
         st_next.fsm                = sld_pkg::SLD_HOLD;
         st_next.cfg.valid          = 1'b0;
         st_next.cfg.in_reset       = 1'b1;
         st_next.cfg.smbus_master   = 1'b0;
         st_next.cfg.smbus_slave    = 1'b0;
         st_next.cfg.mode_reserved  = 1'b0;
         st_next.cfg.usb2_off       = `SLD_PORT_OFF_RST;
         st_next.cfg.usb3_off       = `SLD_PORT_OFF_RST;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         st_reg.fsm                <= sld_pkg::SLD_HOLD;
         st_reg.cnt                <= '0;
         st_reg.strap              <= '0;
         st_reg.cfg.valid          <= 1'b0;
         st_reg.cfg.in_reset       <= 1'b1;
         st_reg.cfg.mode           <= sld_pkg::bridge_master_setting;
         st_reg.cfg.smbus_master   <= 1'b0;
         st_reg.cfg.smbus_slave    <= 1'b0;
         st_reg.cfg.mode_reserved  <= 1'b0;
         st_reg.cfg.usb2_off       <= `SLD_PORT_OFF_RST;
         st_reg.cfg.usb3_off       <= `SLD_PORT_OFF_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_hub_in_reset  = st_reg.cfg.in_reset;
   assign o_cfg_valid     = st_reg.cfg.valid;
   assign o_mode          = st_reg.cfg.mode;
   assign o_smbus_master  = st_reg.cfg.smbus_master;
   assign o_smbus_slave   = st_reg.cfg.smbus_slave;
   assign o_mode_reserved = st_reg.cfg.mode_reserved;
   assign o_usb2_port_off = st_reg.cfg.usb2_off;
   assign o_usb3_port_off = st_reg.cfg.usb3_off;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   // Timing below assumes the default settle of four cycles
   a_release_to_valid: assert property (
      ($rose(ext_rstn_sync) ##1 ext_rstn_sync [*7]) |-> o_cfg_valid
   ) else $error("config not valid seven cycles after reset release");

   a_capture_at_latch: assert property (
      (st_reg.fsm == sld_pkg::SLD_LATCH) |=> (st_reg.strap == $past(strap_sync))
   ) else $error("strap capture does not match synchronised pins");

   a_bridge_master: assert property (
      (o_cfg_valid && o_mode == sld_pkg::bridge_master_setting)
         |-> (o_smbus_master && !o_smbus_slave && !o_mode_reserved)
   ) else $error("bridging setting did not select SMBus master");

   a_slave_config: assert property (
      (o_cfg_valid && o_mode == sld_pkg::hub_config_slave_setting)
         |-> (o_smbus_slave && !o_smbus_master && !o_mode_reserved)
   ) else $error("slave setting did not select SMBus slave");

   a_reserved_inert: assert property (
      o_mode_reserved |-> (!o_smbus_master && !o_smbus_slave && o_cfg_valid)
   ) else $error("reserved setting enabled a function");

   a_port_both_high: assert property (
      o_cfg_valid |-> (o_usb2_port_off ==
                       (st_reg.strap.dplus_off & st_reg.strap.dminus_off))
   ) else $error("port disable differs from both-straps-high rule");

   a_usb3_follows: assert property (
      o_cfg_valid |-> (o_usb3_port_off == o_usb2_port_off)
   ) else $error("USB 3 path disable does not follow USB 2 path");

   a_ext_reset_hold: assert property (
      !ext_rstn_sync |=> (o_hub_in_reset && !o_cfg_valid)
   ) else $error("hub left reset while external reset low");

   a_latched_stable: assert property (
      (o_cfg_valid && $past(o_cfg_valid))
         |-> ($stable(o_usb2_port_off) && $stable(o_mode) && $stable(st_reg.strap))
   ) else $error("latched configuration changed without reset");

   c_bridge_run: cover property (o_cfg_valid && o_smbus_master);
   c_slave_run: cover property (o_cfg_valid && o_smbus_slave);
   c_reserved_run: cover property (o_cfg_valid && o_mode_reserved);
   c_port_off: cover property (o_cfg_valid && (o_usb2_port_off != '0));

endmodule

// ### hdl/sld_sync.sv
// Three-stage pin synchroniser with agreement filter for all strap pins.
// Assumes asynchronous pin levels and one core clock.
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_sync (
   // Clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rstn,
   // Pin side
   input  wire logic [`SLD_SYNC_W-1:0] i_pins,
   // Core side
   output logic      [`SLD_SYNC_W-1:0] o_sync
);

   sld_pkg::sld_sync_t     st_reg;
   sld_pkg::sld_sync_t     st_next;
   logic [`SLD_SYNC_W-1:0] filt_bit;

   // ****************************************
   // Per-bit filter
   // ****************************************
   // Only the second and third stages are compared; the first is metastable-prone
   genvar gi;
   generate
      for (gi = 0; gi < `SLD_SYNC_W; gi++) begin : g_bit
         assign filt_bit[gi] = (st_reg.ff2[gi] == st_reg.ff3[gi]) ?
                               st_reg.ff3[gi] : st_reg.filt[gi];
      end
   endgenerate

   always_comb begin
      st_next      = st_reg;
      st_next.ff1  = i_pins;
      st_next.ff2  = st_reg.ff1;
      st_next.ff3  = st_reg.ff2;
      st_next.filt = filt_bit;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         st_reg <= {4{`SLD_SYNC_RST}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_sync = st_reg.filt;

endmodule

// ### verification/sld_board_model.sv
// Board side of the strap latch decoder: strap resistors and reset driver.
// Assumes the bench sets the wanted levels and reset hold at falling edges.
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_board_model (
   // Clock
   input  wire logic                   i_core_clk,
   // Bench requests
   input  wire logic                   i_hold_reset,
   input  wire logic [`SLD_CODE_W-1:0] i_mode_sel,
   input  wire logic [`SLD_PORTS-1:0]  i_dplus_sel,
   input  wire logic [`SLD_PORTS-1:0]  i_dminus_sel,
   // Pins toward the device
   output logic                        o_ext_reset_n,
   output logic      [`SLD_CODE_W-1:0] o_mode_strap_code,
   output logic      [`SLD_PORTS-1:0]  o_port_dplus_off_strap,
   output logic      [`SLD_PORTS-1:0]  o_port_dminus_off_strap
);
   // ****************************************
   // Strap resistors and reset release
   // ****************************************
   logic [1:0] release_pipe;

   initial begin
      o_ext_reset_n           = 1'b1;
      release_pipe            = 2'h3;
      o_mode_strap_code       = 3'h0;
      o_port_dplus_off_strap  = 6'h00;
      o_port_dminus_off_strap = 6'h00;
   end

   // Reserved codes only reach the pins when the bench asks for them
   // A port is switched off only by tying both of its straps high
   // Release lags the strap change so levels are settled at latch time
   always @(negedge i_core_clk) begin
      o_mode_strap_code       <= i_mode_sel;
      o_port_dplus_off_strap  <= i_dplus_sel;
      o_port_dminus_off_strap <= i_dminus_sel;
      release_pipe            <= {release_pipe[0], ~i_hold_reset};
      o_ext_reset_n           <= release_pipe[1] & ~i_hold_reset;
   end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the strap latch decoder.
// Assumes the board model drives all pins; power-on reset comes from here.
`timescale 1ns/1ps
`include "sld_regs.svh"

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); end end

module testbench;
   // ****************************************
   // Signals
   // ****************************************
   logic                   clk = 1'b0;
   logic                   rstn = 1'b0;
   logic                   hold_reset = 1'b0;
   logic [`SLD_CODE_W-1:0] mode_sel = 3'h1;
   logic [`SLD_PORTS-1:0]  dp_sel = 6'h15;
   logic [`SLD_PORTS-1:0]  dm_sel = 6'h15;
   logic                   ext_reset_n;
   logic [`SLD_CODE_W-1:0] mode_code;
   logic [`SLD_PORTS-1:0]  dp_pin;
   logic [`SLD_PORTS-1:0]  dm_pin;
   logic                   in_reset;
   logic                   cfg_valid;
   sld_pkg::sld_mode_t     mode;
   logic                   smb_master;
   logic                   smb_slave;
   logic                   mode_res;
   logic [`SLD_PORTS-1:0]  usb2_off;
   logic [`SLD_PORTS-1:0]  usb3_off;
   int                     errors = 0;
   int                     check_count = 0;
   int                     cycles = 0;

   always #2 clk = ~clk;

   sld_board_model board (
      .i_core_clk              (clk),
      .i_hold_reset            (hold_reset),
      .i_mode_sel              (mode_sel),
      .i_dplus_sel             (dp_sel),
      .i_dminus_sel            (dm_sel),
      .o_ext_reset_n           (ext_reset_n),
      .o_mode_strap_code       (mode_code),
      .o_port_dplus_off_strap  (dp_pin),
      .o_port_dminus_off_strap (dm_pin)
   );

   sld_strap_latch dut (
      .i_core_clk              (clk),
      .i_rstn                  (rstn),
      .i_ext_reset_n           (ext_reset_n),
      .i_mode_strap_code       (mode_code),
      .i_port_dplus_off_strap  (dp_pin),
      .i_port_dminus_off_strap (dm_pin),
      .o_hub_in_reset          (in_reset),
      .o_cfg_valid             (cfg_valid),
      .o_mode                  (mode),
      .o_smbus_master          (smb_master),
      .o_smbus_slave           (smb_slave),
      .o_mode_reserved         (mode_res),
      .o_usb2_port_off         (usb2_off),
      .o_usb3_port_off         (usb3_off)
   );

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Bounded wait; the latch needs roughly a dozen edges after release
   task automatic wait_valid();
      int n;
      n = 0;
      while (cfg_valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      `CHK(cfg_valid, 1'b1)
   endtask

   task automatic check_outputs(input logic [2:0] code, input logic [5:0] dp,
                                input logic [5:0] dm);
      `CHK(in_reset, 1'b0)
      // Codes the sensor never produces fold into the last reserved setting
      `CHK(mode, (code > 3'h5) ? sld_pkg::reserved_setting_d : sld_pkg::sld_mode_t'(code))
      `CHK(smb_master, code == 3'h0)
      `CHK(smb_slave, code == 3'h1)
      `CHK(mode_res, code >= 3'h2)
      `CHK(usb2_off, dp & dm)
      `CHK(usb3_off, dp & dm)
   endtask

   // Holds the pin low, checks standby outputs, then latches new straps
   task automatic ext_cycle(input logic [2:0] code, input logic [5:0] dp,
                            input logic [5:0] dm);
      hold_reset = 1'b1;
      repeat (12) @(negedge clk);
      `CHK(in_reset, 1'b1)
      `CHK(cfg_valid, 1'b0)
      `CHK(usb2_off, 6'h3F)
      `CHK(usb3_off, 6'h3F)
      `CHK(smb_master, 1'b0)
      `CHK(smb_slave, 1'b0)
      `CHK(mode_res, 1'b0)
      mode_sel = code;
      dp_sel   = dp;
      dm_sel   = dm;
      repeat (2) @(negedge clk);
      hold_reset = 1'b0;
      wait_valid();
      check_outputs(code, dp, dm);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_por_latch();
      wait_valid();
      check_outputs(3'h1, 6'h15, 6'h15);
   endtask

   task automatic test_all_modes();
      for (int c = 0; c < 8; c++) begin
         ext_cycle(3'(c), 6'h00, 6'h00);
      end
   endtask

   // Single-sided straps must leave their port on
   task automatic test_port_pairs();
      ext_cycle(3'h0, 6'h2B, 6'h1E);
      ext_cycle(3'h1, 6'h3F, 6'h3F);
      ext_cycle(3'h2, 6'h3F, 6'h00);
      ext_cycle(3'h3, 6'h00, 6'h3F);
   endtask

   task automatic test_late_change();
      ext_cycle(3'h1, 6'h21, 6'h21);
      mode_sel = 3'h0;
      dp_sel   = 6'h3F;
      dm_sel   = 6'h3F;
      repeat (30) @(negedge clk);
      `CHK(cfg_valid, 1'b1)
      check_outputs(3'h1, 6'h21, 6'h21);
   endtask

   // Power-on reset in mid-run relatches the current straps
   task automatic test_por_again();
      rstn = 1'b0;
      repeat (5) @(negedge clk);
      `CHK(in_reset, 1'b1)
      `CHK(cfg_valid, 1'b0)
      rstn = 1'b1;
      wait_valid();
      check_outputs(3'h0, 6'h3F, 6'h3F);
   endtask

   // ****************************************
   // Main sequence and timeout
   // ****************************************
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 5000) begin
         errors++;
         $display("Error at %0t ns: timeout", $time);
         wrap_up();
      end
   end

   initial begin
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      test_por_latch();
      test_all_modes();
      test_port_pairs();
      test_late_change();
      test_por_again();
      wrap_up();
   end
endmodule
